/* hdl/usm_pkg.sv */
// Constants for the USART master-SPI block: register map, fields, resets.
// Assumes a plain address/strobe register port on the 100 MHz system clock.
package usm_pkg;
	// ****************************************************************
	// Register offsets
	// ****************************************************************
	localparam logic [2:0] USM_ADDR_DATA = 3'h0;
	localparam logic [2:0] USM_ADDR_STAT_A = 3'h1;
	localparam logic [2:0] USM_ADDR_CTRL_B = 3'h2;
	localparam logic [2:0] USM_ADDR_CTRL_C = 3'h3;
	localparam logic [2:0] USM_ADDR_BAUD_LO = 3'h4;
	localparam logic [2:0] USM_ADDR_BAUD_HI = 3'h5;
	localparam logic [2:0] USM_ADDR_GIE = 3'h6;
	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int USM_A_RXC = 7;
	localparam int USM_A_TXC = 6;
	localparam int USM_A_UDRE = 5;
	localparam int USM_B_RXCIE = 7;
	localparam int USM_B_TXCIE = 6;
	localparam int USM_B_TX_EMPTY_IRQ_EN = 5;
	localparam int USM_B_RXEN = 4;
	localparam int USM_B_TXEN = 3;
	localparam int USM_C_ORDER = 2;
	localparam int USM_C_PHASE = 1;
	localparam int USM_C_POL = 0;
	// ****************************************************************
	// Reset values and modes
	// ****************************************************************
	localparam logic [7:0] USM_CTRL_B_RST = 8'h00;
	localparam logic [7:0] USM_CTRL_C_RST = 8'h06;
	localparam logic [11:0] USM_BAUD_RST = 12'h000;
	localparam logic [1:0] USM_MODE_ASYNC = 2'h0;
	localparam logic [1:0] USM_MODE_SYNC = 2'h1;
	localparam logic [1:0] USM_MODE_RSVD = 2'h2;
	localparam logic [1:0] USM_MODE_MSPI = 2'h3;
	localparam int USM_FRAME_BITS = 8;
	localparam int USM_RX_DEPTH = 2;
endpackage : usm_pkg

/* hdl/usm_master_spi.sv */
// USART in master-only SPI mode: double-buffered transmit, two-level receive.
// Assumes register access from a same-clock master; miso is asynchronous.
`timescale 1ns/100ps
// Operation
// - Error flags in status read as zero
// - Receive flag follows unread receive data
// - Transmit complete sets, cleared by ack/write-one
// - Empty flag high when buffer free, reset
// - Receive irq needs enable, global, flag
// - Transmit irq needs enable, global, flag
// - Empty irq needs enable, global, flag
// - Receiver enable owns input; clear flushes
// - Receiver alone never starts a transfer
// - Transmitter disable waits until all empty
// - Mode field decodes four modes; the code acts only on master SPI (3), the other three start no transfer
// - Order, phase, polarity apply with mode write
// - Order bit selects LSB or MSB first
// - Phase bit picks leading or trailing sample
// - Polarity bit sets clock idle level
// - Double transmit buffer, extra receive level
// - Master only: MOSI, MISO, SCK, no select
// - Data write starts transfer via shift register
// - Overflow drops newest received byte
// - Shift and sample on opposite edges
module usm_master_spi
	import usm_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire logic [2:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	// Interrupt acknowledge for transmit complete
	input wire logic tx_complete_ack_i,
	// Interrupt requests
	output logic rx_complete_irq_o,
	output logic tx_complete_irq_o,
	output logic tx_empty_irq_o,
	// Pins
	output logic serial_out_pin_o,
	output logic serial_out_pin_oe_o,
	input wire logic serial_in_pin_i,
	output logic transfer_clock_pin_o,
	output logic transfer_clock_pin_oe_o,
	output logic master_spi_mode_o
);
	// ****************************************************************
	// State and registers
	// ****************************************************************
	typedef enum logic [1:0] {USM_IDLE, USM_LEAD, USM_TRAIL} usm_state_e;
	usm_state_e state_r; // Bit phase state
	logic [7:0] ctrl_b_r; // Control B
	logic [7:0] ctrl_c_r; // Control C
	logic [11:0] baud_r; // Baud divisor
	logic gie_r; // Global interrupt flag
	logic [7:0] txbuf_r; // Transmit buffer
	logic txbuf_full_r; // Transmit buffer holds data
	logic [7:0] shift_r; // Transmit shift register
	logic [7:0] rxsh_r; // Receive shift register
	logic [2:0] bitcnt_r; // Bits done in frame
	logic shifting_r; // Shift register busy
	logic [11:0] bdiv_r; // Half-period counter
	logic sck_r; // Transfer clock level
	logic mosi_r; // Output data level
	logic txc_r; // Transmit complete flag
	logic txen_act_r; // Transmitter owns output pin
	logic [7:0] rxmem_r [USM_RX_DEPTH]; // Receive buffer levels
	logic [1:0] rxcnt_r; // Unread bytes
	logic rxrd_r; // Read pointer
	logic miso_s1_r; // Synchroniser first stage
	logic miso_s2_r; // Synchroniser second stage
	logic [7:0] rdata_r; // Read data
	// ****************************************************************
	// Decoding
	// ****************************************************************
	wire logic wr_data = reg_wr_i && reg_addr_i == USM_ADDR_DATA;
	wire logic rd_data = reg_rd_i && reg_addr_i == USM_ADDR_DATA;
	wire logic wr_stat = reg_wr_i && reg_addr_i == USM_ADDR_STAT_A;
	wire logic wr_ctrl_b = reg_wr_i && reg_addr_i == USM_ADDR_CTRL_B;
	wire logic wr_ctrl_c = reg_wr_i && reg_addr_i == USM_ADDR_CTRL_C;
	wire logic [1:0] mode = ctrl_c_r[7:6];
	wire logic mspi = mode == USM_MODE_MSPI;
	wire logic lsb_first = ctrl_c_r[USM_C_ORDER];
	wire logic cpha = ctrl_c_r[USM_C_PHASE];
	wire logic cpol = ctrl_c_r[USM_C_POL];
	wire logic rxen = ctrl_b_r[USM_B_RXEN];
	wire logic txen = ctrl_b_r[USM_B_TXEN];
	wire logic udre = !txbuf_full_r;
	wire logic rxc = rxcnt_r != 2'h0;
	wire logic half_tick = bdiv_r == 12'h000;
	// Only the transmitter makes the clock; receiver alone idles
	wire logic start_frame = mspi && txen_act_r && !shifting_r && txbuf_full_r;
	wire logic lead_edge = shifting_r && half_tick && state_r == USM_LEAD;
	wire logic trail_edge = shifting_r && half_tick && state_r == USM_TRAIL;
	// Sample on leading edge when phase 0, on trailing when 1
	wire logic sample_now = cpha ? trail_edge : lead_edge;
	wire logic last_bit = bitcnt_r == 3'(USM_FRAME_BITS - 1);
	wire logic frame_end = trail_edge && last_bit;
	wire logic [7:0] rx_next = lsb_first ? {miso_s2_r, rxsh_r[7:1]}
		: {rxsh_r[6:0], miso_s2_r};
	// Phase 1 takes its last sample at frame end; phase 0 already holds all eight
	wire logic [7:0] rx_byte = rxen ? (cpha ? rx_next : rxsh_r) : 8'h00;
	wire logic rx_push = frame_end && rxen && rxcnt_r != 2'(USM_RX_DEPTH);
	wire logic rx_pop = rd_data && rxc;
	wire logic [0:0] rx_wr_idx = rxrd_r ^ rxcnt_r[0];

	// Outbound bit for the current shift position
	function automatic logic out_bit(input logic [7:0] d, input logic lsb);
		out_bit = lsb ? d[0] : d[7];
	endfunction : out_bit

	function automatic logic [7:0] shift_on(input logic [7:0] d, input logic lsb);
		shift_on = lsb ? {1'b0, d[7:1]} : {d[6:0], 1'b0};
	endfunction : shift_on

	// ****************************************************************
	// Read mux; error flags in bits 4:0 read zero
	// ****************************************************************
	wire logic [7:0] stat_a = {rxc, txc_r, udre, 5'h00};
	wire logic [7:0] rd_mux =
		reg_addr_i == USM_ADDR_DATA ? rxmem_r[rxrd_r] :
		reg_addr_i == USM_ADDR_STAT_A ? stat_a :
		reg_addr_i == USM_ADDR_CTRL_B ? {ctrl_b_r[7:3], 3'h0} :
		reg_addr_i == USM_ADDR_CTRL_C ? {ctrl_c_r[7:6], 3'h0, ctrl_c_r[2:0]} :
		reg_addr_i == USM_ADDR_BAUD_LO ? baud_r[7:0] :
		reg_addr_i == USM_ADDR_BAUD_HI ? {4'h0, baud_r[11:8]} :
		reg_addr_i == USM_ADDR_GIE ? {7'h00, gie_r} : 8'h00;

	// Read data valid the cycle after the strobe
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			rdata_r <= 8'h00;
		else
			rdata_r <= reg_rd_i ? rd_mux : 8'h00;
	end

	// ****************************************************************
	// Control registers
	// ****************************************************************
	// Reserved bits stored as zero regardless of software
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			ctrl_b_r <= USM_CTRL_B_RST;
			ctrl_c_r <= USM_CTRL_C_RST;
			baud_r <= USM_BAUD_RST;
			gie_r <= 1'b0;
		end
		else
		begin
			if (wr_ctrl_b)
				ctrl_b_r <= {reg_wdata_i[7:3], 3'h0};
			// Mode and framing bits land in one write
			if (wr_ctrl_c)
				ctrl_c_r <= {reg_wdata_i[7:6], 3'h0, reg_wdata_i[2:0]};
			if (reg_wr_i && reg_addr_i == USM_ADDR_BAUD_LO)
				baud_r[7:0] <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == USM_ADDR_BAUD_HI)
				baud_r[11:8] <= reg_wdata_i[3:0];
			if (reg_wr_i && reg_addr_i == USM_ADDR_GIE)
				gie_r <= reg_wdata_i[0];
		end
	end

	// Transmitter ownership: off only once everything drained
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			txen_act_r <= 1'b0;
		else if (txen)
			txen_act_r <= 1'b1;
		else if (!shifting_r && !txbuf_full_r)
			txen_act_r <= 1'b0;
	end

	// ****************************************************************
	// Transmit buffer (second transmit level)
	// ****************************************************************
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			txbuf_r <= 8'h00;
			txbuf_full_r <= 1'b0;
		end
		else if (wr_data && udre && txen)
		begin
			txbuf_r <= reg_wdata_i;
			txbuf_full_r <= 1'b1;
		end
		else if (start_frame)
			txbuf_full_r <= 1'b0;
	end

	// ****************************************************************
	// Shift engine
	// ****************************************************************
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			state_r <= USM_IDLE;
			shifting_r <= 1'b0;
			shift_r <= 8'h00;
			rxsh_r <= 8'h00;
			bitcnt_r <= 3'h0;
			bdiv_r <= 12'h000;
			sck_r <= 1'b0;
			mosi_r <= 1'b1;
		end
		else
		begin
			bdiv_r <= (half_tick || !shifting_r) ? baud_r : bdiv_r - 12'h001;
			if (sample_now)
				rxsh_r <= rx_next;
			case (state_r)
				USM_IDLE:
				begin
					sck_r <= cpol;
					if (start_frame)
					begin
						shifting_r <= 1'b1;
						shift_r <= txbuf_r;
						bitcnt_r <= 3'h0;
						state_r <= USM_LEAD;
						// Phase 0 presents the first bit before the leading edge
						if (!cpha)
							mosi_r <= out_bit(txbuf_r, lsb_first);
					end
				end
				USM_LEAD:
				begin
					if (half_tick)
					begin
						sck_r <= !cpol;
						state_r <= USM_TRAIL;
						// Phase 1 sets up on the leading edge
						if (cpha)
						begin
							mosi_r <= out_bit(shift_r, lsb_first);
							shift_r <= shift_on(shift_r, lsb_first);
						end
						else
							shift_r <= shift_on(shift_r, lsb_first);
					end
				end
				USM_TRAIL:
				begin
					if (half_tick)
					begin
						sck_r <= cpol;
						bitcnt_r <= bitcnt_r + 3'h1;
						if (last_bit)
						begin
							shifting_r <= 1'b0;
							state_r <= USM_IDLE;
						end
						else
						begin
							state_r <= USM_LEAD;
							// Phase 0 sets up on the trailing edge
							if (!cpha)
								mosi_r <= out_bit(shift_r, lsb_first);
						end
					end
				end
				default:
					state_r <= USM_IDLE;
			endcase
		end
	end

	// Transmit complete: set wins over clear
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
			txc_r <= 1'b0;
		else if (frame_end && !txbuf_full_r)
			txc_r <= 1'b1;
		else if (tx_complete_ack_i || (wr_stat && reg_wdata_i[USM_A_TXC]))
			txc_r <= 1'b0;
	end

	// ****************************************************************
	// Receive side: input synchroniser and two-level buffer
	// ****************************************************************
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i)
		begin
			miso_s1_r <= 1'b0;
			miso_s2_r <= 1'b0;
		end
		else
		begin
			miso_s1_r <= serial_in_pin_i;
			miso_s2_r <= miso_s1_r;
		end
	end

	// Frame end stores byte; overflow drops newest
	always_ff @(posedge ref_clk_i)
	begin
		if (rx_push)
			rxmem_r[rx_wr_idx] <= rx_byte;
	end

	// Unread count and pointer; disable flushes
	always_ff @(posedge ref_clk_i)
	begin
		if (sys_rst_i || !rxen)
		begin
			rxcnt_r <= 2'h0;
			rxrd_r <= 1'b0;
		end
		else
		begin
			rxcnt_r <= rxcnt_r + 2'(rx_push) - 2'(rx_pop);
			if (rx_pop)
				rxrd_r <= !rxrd_r;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign reg_rdata_o = rdata_r;
	assign rx_complete_irq_o = ctrl_b_r[USM_B_RXCIE] && gie_r && rxc;
	assign tx_complete_irq_o = ctrl_b_r[USM_B_TXCIE] && gie_r && txc_r;
	assign tx_empty_irq_o = ctrl_b_r[USM_B_TX_EMPTY_IRQ_EN] && gie_r && udre;
	// Master-only pins, no select input
	assign serial_out_pin_o = mosi_r;
	assign serial_out_pin_oe_o = txen_act_r;
	assign transfer_clock_pin_o = sck_r;
	assign transfer_clock_pin_oe_o = mspi && txen_act_r;
	assign master_spi_mode_o = mspi;
endmodule : usm_master_spi

/* testbench/usm_checker.sv */
// Port checker for the USART master-SPI block.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
module usm_checker
	import usm_pkg::*;
(
	// Clock, reset, register port
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [2:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic tx_complete_ack_i,
	// Requests and pins
	input wire logic rx_complete_irq_o,
	input wire logic tx_complete_irq_o,
	input wire logic tx_empty_irq_o,
	input wire logic serial_out_pin_o,
	input wire logic serial_out_pin_oe_o,
	input wire logic serial_in_pin_i,
	input wire logic transfer_clock_pin_o,
	input wire logic transfer_clock_pin_oe_o,
	input wire logic master_spi_mode_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);
	// Status read, answered in the next cycle
	sequence stat_rd;
		reg_rd_i && reg_addr_i == USM_ADDR_STAT_A;
	endsequence
	// Write of the mode register
	sequence mode_wr;
		reg_wr_i && reg_addr_i == USM_ADDR_CTRL_C;
	endsequence
	err_flags_a: assert property (stat_rd |=> reg_rdata_o[4:0] == 5'h00)
		else $error("error flags not zero");
	rx_irq_a: assert property (stat_rd ##0 rx_complete_irq_o |=> reg_rdata_o[7])
		else $error("receive request without flag");
	tx_irq_a: assert property (stat_rd ##0 tx_complete_irq_o |=> reg_rdata_o[6])
		else $error("transmit request without flag");
	empty_irq_a: assert property (stat_rd ##0 tx_empty_irq_o |=> reg_rdata_o[5])
		else $error("empty request without flag");
	mode_on_a: assert property (mode_wr ##0 reg_wdata_i[7:6] == 2'h3 |=> master_spi_mode_o)
		else $error("spi mode not entered");
	mode_off_a: assert property (mode_wr ##0 reg_wdata_i[7:6] != 2'h3 |=> !master_spi_mode_o)
		else $error("spi mode not left");
	sck_own_a: assert property (transfer_clock_pin_oe_o |-> master_spi_mode_o && serial_out_pin_oe_o)
		else $error("clock pin driven outside spi mode");
	sck_quiet_a: assert property ($changed(transfer_clock_pin_o) |-> serial_out_pin_oe_o
		|| $past(reg_wr_i) || $past(reg_wr_i, 2))
		else $error("clock moved with transmitter off");
	tx_ack_a: assert property (tx_complete_ack_i && tx_complete_irq_o && !reg_wr_i
		|=> !tx_complete_irq_o)
		else $error("acknowledge did not clear");
	pin_free_a: assert property ($fell(serial_out_pin_oe_o) |-> !transfer_clock_pin_oe_o
		&& $stable(transfer_clock_pin_o))
		else $error("pin released mid frame");
endmodule : usm_checker

/* testbench/usm_spi_slave_model.sv */
// SPI slave stand-in: returns each received byte in the next frame.
// Assumes the bench pulses rst_i after every mode change.
`timescale 1ns/100ps
module usm_spi_slave_model
(
	// Mode and reset from the bench
	input wire logic rst_i,
	input wire logic cpol_i,
	input wire logic cpha_i,
	input wire logic lsb_first_i,
	// Serial pins
	input wire logic sck_i,
	input wire logic mosi_i,
	output logic miso_o,
	output logic [7:0] rx_byte_o
);
	logic [7:0] rx_r = 8'h00;
	logic [7:0] tx_r = 8'h5A;
	logic [2:0] idx_r = 3'h0; // Bit now presented
	logic [2:0] cnt_r = 3'h0; // Bits sampled so far
	logic sck_q = 1'b0;
	// Both directions share one bit order
	assign miso_o = tx_r[lsb_first_i ? idx_r : 3'h7 - idx_r];
	// Sample on one edge, set up on the other
	always @(sck_i or rst_i)
	begin
		if (rst_i)
		begin
			cnt_r = 3'h0;
			idx_r = 3'h0;
		end
		else if (sck_i !== sck_q)
		begin
			if (sck_i == (cpol_i ~^ cpha_i))
			begin
				rx_r[lsb_first_i ? cnt_r : 3'h7 - cnt_r] = mosi_i;
				if (cnt_r == 3'h7)
				begin
					rx_byte_o = rx_r;
					tx_r = rx_r;
				end
				cnt_r = cnt_r + 3'h1;
			end
			else
				idx_r = cnt_r;
		end
		sck_q = sck_i;
	end
endmodule : usm_spi_slave_model

/* testbench/usm_master_spi_tb.sv */
// Self-checking bench for the USART master-SPI block.
// Assumes the slave model answers every frame.
`timescale 1ns/100ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin miscompares++; $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module usm_master_spi_tb;
	import usm_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic srst = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr_s = 1'b0;
	logic rd_s = 1'b0;
	logic ack = 1'b0;
	logic cpol = 1'b0;
	logic cpha = 1'b0;
	logic lsb = 1'b0;
	logic [7:0] rdata, srx, d, prev;
	logic irq_rx, irq_tx, irq_e, mosi, mosi_oe, miso, sck, sck_oe, mspi;
	int miscompares = 0;
	int n_compared = 0;
	always #5 clk = ~clk;
	usm_master_spi u_usm_master_spi (.ref_clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s), .reg_rdata_o(rdata),
		.tx_complete_ack_i(ack), .rx_complete_irq_o(irq_rx), .tx_complete_irq_o(irq_tx),
		.tx_empty_irq_o(irq_e), .serial_out_pin_o(mosi), .serial_out_pin_oe_o(mosi_oe),
		.serial_in_pin_i(miso), .transfer_clock_pin_o(sck),
		.transfer_clock_pin_oe_o(sck_oe), .master_spi_mode_o(mspi));
	usm_spi_slave_model u_usm_spi_slave_model (.rst_i(srst), .cpol_i(cpol), .cpha_i(cpha),
		.lsb_first_i(lsb), .sck_i(sck), .mosi_i(mosi), .miso_o(miso), .rx_byte_o(srx));
	// Register bus cycles; callers keep reserved bits zero
	task automatic wr(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1 v = rdata;
	endtask : rd
	// Poll a status bit, bounded
	task automatic poll(input int b);
		d = 8'h00;
		for (int i = 0; i < 300 && d[b] !== 1'b1; i++)
			rd(USM_ADDR_STAT_A, d);
		`CHK("poll", 1'b1, d[b])
	endtask : poll
	task automatic t_reset;
		rd(USM_ADDR_STAT_A, d);
		`CHK("status", 8'h20, d)
		rd(USM_ADDR_CTRL_C, d);
		`CHK("ctrl_c", 8'h06, d)
		wr(USM_ADDR_BAUD_LO, 8'h07);
		wr(USM_ADDR_CTRL_B, 8'h18);
	endtask : t_reset
	// One frame in each clock mode, order toggled
	task automatic t_modes;
		logic [7:0] v;
		for (int m = 0; m < 4; m++)
		begin
			v = 8'h1D + 8'h40 * m[7:0];
			cpol <= m[0];
			cpha <= m[1];
			lsb <= m[0] ^ m[1];
			wr(USM_ADDR_CTRL_C, {2'h3, 3'h0, m[0] ^ m[1], m[1], m[0]});
			srst <= 1'b1;
			repeat (3) @(posedge clk);
			srst <= 1'b0;
			wr(USM_ADDR_DATA, v);
			poll(7);
			`CHK("slave_rx", v, srx)
			`CHK("sck_idle", m[0], sck)
			`CHK("sck_oe", 1'b1, sck_oe)
			rd(USM_ADDR_DATA, d);
			`CHK("rx_data", prev, d)
			prev = v;
		end
	endtask : t_modes
	// Three frames, none read until the end
	task automatic t_buffer;
		wr(USM_ADDR_STAT_A, 8'h40);
		wr(USM_ADDR_DATA, 8'h11);
		wr(USM_ADDR_DATA, 8'h22);
		rd(USM_ADDR_STAT_A, d);
		`CHK("udre_full", 1'b0, d[5])
		poll(5);
		wr(USM_ADDR_DATA, 8'h33);
		poll(6);
		rd(USM_ADDR_DATA, d);
		`CHK("first", prev, d)
		rd(USM_ADDR_DATA, d);
		`CHK("second", 8'h11, d)
		rd(USM_ADDR_STAT_A, d);
		`CHK("rxc_empty", 1'b0, d[7])
	endtask : t_buffer
	task automatic t_flush;
		wr(USM_ADDR_DATA, 8'h44);
		poll(7);
		wr(USM_ADDR_CTRL_B, 8'h08);
		rd(USM_ADDR_STAT_A, d);
		`CHK("flushed", 1'b0, d[7])
	endtask : t_flush
	// Transmitter disable drains its frame; then receiver alone: nothing moves
	task automatic t_txoff;
		wr(USM_ADDR_STAT_A, 8'h40);
		wr(USM_ADDR_DATA, 8'h4B);
		wr(USM_ADDR_CTRL_B, 8'h00);
		`CHK("oe_hold", 1'b1, mosi_oe)
		poll(6);
		wr(USM_ADDR_CTRL_B, 8'h10);
		repeat (4) @(posedge clk);
		`CHK("mosi_oe", 1'b0, mosi_oe)
		`CHK("sck_oe_off", 1'b0, sck_oe)
		wr(USM_ADDR_DATA, 8'h55);
		repeat (300) @(posedge clk);
		rd(USM_ADDR_STAT_A, d);
		`CHK("no_rx", 1'b0, d[7])
		`CHK("no_frame", 8'h4B, srx)
		wr(USM_ADDR_CTRL_B, 8'h18);
	endtask : t_txoff
	task automatic t_irq;
		wr(USM_ADDR_STAT_A, 8'h40);
		wr(USM_ADDR_GIE, 8'h01);
		wr(USM_ADDR_CTRL_B, 8'hF8);
		`CHK("irq_e", 1'b1, irq_e)
		`CHK("irq_tx0", 1'b0, irq_tx)
		wr(USM_ADDR_DATA, 8'h66);
		poll(6);
		`CHK("irq_rx", 1'b1, irq_rx)
		`CHK("irq_tx", 1'b1, irq_tx)
		@(posedge clk);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		#1 `CHK("irq_ack", 1'b0, irq_tx)
		wr(USM_ADDR_GIE, 8'h00);
		`CHK("irq_off", 3'h0, {irq_rx, irq_tx, irq_e})
		rd(USM_ADDR_DATA, d);
		`CHK("echo", 8'h4B, d)
	endtask : t_irq
	task automatic t_modesel;
		for (int v = 0; v < 4; v++)
		begin
			wr(USM_ADDR_CTRL_C, {v[1:0], 6'h00});
			`CHK("mode", v == 3, mspi)
		end
	endtask : t_modesel
	task automatic conclude;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : conclude
	// Main sequence
	initial
	begin
		prev = 8'h5A;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		srst <= 1'b0;
		t_reset;
		t_modes;
		t_buffer;
		t_flush;
		t_txoff;
		t_irq;
		t_modesel;
		conclude;
	end
	// Watchdog
	initial
	begin
		#100000;
		miscompares++;
		conclude;
	end
endmodule : usm_master_spi_tb
bind usm_master_spi usm_checker u_usm_checker (.*);
